// *** hw/otd_defs.svh ***
`ifndef OTD_DEFS_SVH
`define OTD_DEFS_SVH

// ----------------------------------------
// widths
// ----------------------------------------
`define OTD_ADDR_W          10
`define OTD_BUS_W           32
`define OTD_REG_W           24
`define OTD_PIN_SEL_W       16

// ----------------------------------------
// register offsets
// ----------------------------------------
`define OTD_A_PIN_SEL       10'h110
`define OTD_A_VOLT_LIM      10'h224
`define OTD_A_CUR_LIM       10'h225
`define OTD_A_PRI_EN        10'h22C
`define OTD_A_PRI_FLAGS     10'h22D
`define OTD_A_PRI_CLR       10'h22E
`define OTD_A_SEC_EN        10'h22F
`define OTD_A_SEC_FLAGS     10'h230
`define OTD_A_SEC_CLR       10'h231

// ----------------------------------------
// flag bit positions
// ----------------------------------------
`define OTD_BIT_VOLT_OVER   16
`define OTD_BIT_CHAN_A_OVER 13
`define OTD_BIT_CHAN_B_OVER 13
`define OTD_BIT_RESET_DONE  20

// ----------------------------------------
// reset values
// ----------------------------------------
`define OTD_LIMIT_RST       24'hFFFFFF
`define OTD_PIN_SEL_RST     16'h0000
`define OTD_PRI_EN_RST      24'h100000
`define OTD_SEC_EN_RST      24'h000000
`define OTD_FLAGS_RST       24'h000000
`define OTD_FLAGS_ALL       24'hFFFFFF

`endif

// *** hw/otd_pkg.sv ***
package otd_pkg;

    // pin function codes
    typedef enum logic [3:0] {
        OTD_F_VOLT_ZX   = 4'h0,
        OTD_F_CUR_ZX    = 4'h1,
        OTD_F_REV_PWR   = 4'h2,
        OTD_F_SAG       = 4'h3,
        OTD_F_NL_ACT_A  = 4'h4,
        OTD_F_NL_ACT_B  = 4'h5,
        OTD_F_NL_REA_A  = 4'h6,
        OTD_F_NL_REA_B  = 4'h7,
        OTD_F_WAVE_RDY  = 4'h8,
        OTD_F_SEC_IRQ   = 4'h9
    } otd_func_type;

    // pin_function_select layout
    typedef struct packed {
        logic       spare;
        logic [2:0] alt_en;
        logic [3:0] pin20_function_field;
        logic [3:0] pin21_function_field;
        logic [3:0] pin1_function_field;
    } otd_pin_sel_type;

    // live conditions from neighbouring blocks
    typedef struct packed {
        logic       volt_zero_cross;
        logic       current_zero_cross;
        logic       reverse_power;
        logic       sag;
        logic [3:0] no_load;
        logic       wave_ready;
    } otd_live_type;

endpackage

// *** hw/otd_top.sv ***
`include "otd_defs.svh"


module otd_top #(
    parameter int DATA_W = 24
) (
    // clock and reset
    input  wire logic                    clk_in,
    input  wire logic                    rst_b_in,
    input  wire logic                    soft_reset_in,
    // samples
    input  wire logic                    sample_valid_in,
    input  wire logic [DATA_W-1:0]       volt_sample_in,
    input  wire logic [DATA_W-1:0]       chan_a_sample_in,
    input  wire logic [DATA_W-1:0]       chan_b_sample_in,
    // live conditions
    input  wire otd_pkg::otd_live_type   live_in,
    // register port
    input  wire logic                    reg_wr_in,
    input  wire logic                    reg_rd_in,
    input  wire logic [`OTD_ADDR_W-1:0]  reg_addr_in,
    input  wire logic [`OTD_BUS_W-1:0]   reg_wdata_in,
    output logic      [`OTD_BUS_W-1:0]   reg_rdata_out,
    output logic                         reg_rvalid_out,
    // pins
    output logic                         irq_b_out,
    output logic                         pin1_out,
    output logic                         pin21_out,
    output logic                         pin20_out
);

    // ----------------------------------------
    // elaboration checks
    // ----------------------------------------
    if (DATA_W != 24 && DATA_W != 32) begin : g_bad_width
        $error("DATA_W must be 24 or 32");
    end

    // ----------------------------------------
    // functions
    // ----------------------------------------

    // unsigned magnitude of a two's complement sample
    function automatic logic [DATA_W-1:0] mag(input logic [DATA_W-1:0] s);
        mag = s[DATA_W-1] ? (~s + DATA_W'(1)) : s;
    endfunction

    // level of one multi-purpose pin
    function automatic logic pin_level(
        input otd_pkg::otd_live_type live,
        input logic                  sec_irq_b,
        input logic                  alt_en,
        input logic [3:0]            field,
        input logic [3:0]            dflt
    );
        logic [3:0] code;
        code = alt_en ? field : dflt;
        unique case (code)
            otd_pkg::OTD_F_VOLT_ZX:  pin_level = live.volt_zero_cross;
            otd_pkg::OTD_F_CUR_ZX:   pin_level = live.current_zero_cross;
            otd_pkg::OTD_F_REV_PWR:  pin_level = live.reverse_power;
            otd_pkg::OTD_F_SAG:      pin_level = live.sag;
            otd_pkg::OTD_F_NL_ACT_A: pin_level = live.no_load[0];
            otd_pkg::OTD_F_NL_ACT_B: pin_level = live.no_load[1];
            otd_pkg::OTD_F_NL_REA_A: pin_level = live.no_load[2];
            otd_pkg::OTD_F_NL_REA_B: pin_level = live.no_load[3];
            otd_pkg::OTD_F_WAVE_RDY: pin_level = live.wave_ready;
            otd_pkg::OTD_F_SEC_IRQ:  pin_level = sec_irq_b;
            default:                 pin_level = 1'b1; // unused code idles high
        endcase
    endfunction

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [DATA_W-1:0]          volt_limit_reg;
    logic [DATA_W-1:0]          current_limit_reg;
    otd_pkg::otd_pin_sel_type   pin_sel_reg;
    logic [`OTD_REG_W-1:0]      primary_enable_reg;
    logic [`OTD_REG_W-1:0]      secondary_enable_reg;
    logic [`OTD_REG_W-1:0]      primary_flags_reg;
    logic [`OTD_REG_W-1:0]      secondary_flags_reg;
    logic                       boot_reg;
    logic [`OTD_REG_W-1:0]      primary_flags_next;
    logic [`OTD_REG_W-1:0]      secondary_flags_next;

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    wire wr_volt    = reg_wr_in && reg_addr_in == `OTD_A_VOLT_LIM;
    wire wr_cur     = reg_wr_in && reg_addr_in == `OTD_A_CUR_LIM;
    wire wr_pin     = reg_wr_in && reg_addr_in == `OTD_A_PIN_SEL;
    wire wr_pri_en  = reg_wr_in && reg_addr_in == `OTD_A_PRI_EN;
    wire wr_sec_en  = reg_wr_in && reg_addr_in == `OTD_A_SEC_EN;
    wire rd_pri_clr = reg_rd_in && reg_addr_in == `OTD_A_PRI_CLR;
    wire rd_sec_clr = reg_rd_in && reg_addr_in == `OTD_A_SEC_CLR;

    // ----------------------------------------
    // over-limit compare
    // ----------------------------------------
    wire [DATA_W-1:0] volt_mag   = mag(volt_sample_in);
    wire [DATA_W-1:0] chan_a_mag = mag(chan_a_sample_in);
    wire [DATA_W-1:0] chan_b_mag = mag(chan_b_sample_in);

    // strict compare on each new sample only
    wire volt_over   = sample_valid_in && (volt_mag > volt_limit_reg);
    wire chan_a_over = sample_valid_in && (chan_a_mag > current_limit_reg);
    wire chan_b_over = sample_valid_in && (chan_b_mag > current_limit_reg);

    // ----------------------------------------
    // flag set and clear terms
    // ----------------------------------------
    wire [`OTD_REG_W-1:0] primary_set =
        (`OTD_REG_W'(volt_over) << `OTD_BIT_VOLT_OVER) |
        (`OTD_REG_W'(chan_a_over) << `OTD_BIT_CHAN_A_OVER) |
        (`OTD_REG_W'(boot_reg) << `OTD_BIT_RESET_DONE);
    wire [`OTD_REG_W-1:0] secondary_set =
        `OTD_REG_W'(chan_b_over) << `OTD_BIT_CHAN_B_OVER;
    wire [`OTD_REG_W-1:0] primary_clr   = rd_pri_clr ? `OTD_FLAGS_ALL : `OTD_FLAGS_RST;
    wire [`OTD_REG_W-1:0] secondary_clr = rd_sec_clr ? `OTD_FLAGS_ALL : `OTD_FLAGS_RST;

    // set beats a clear in the same cycle; enables play no part
    assign primary_flags_next   = (primary_flags_reg & ~primary_clr) | primary_set;
    assign secondary_flags_next = (secondary_flags_reg & ~secondary_clr) | secondary_set;

    // ----------------------------------------
    // interrupt and pin terms
    // ----------------------------------------
    wire pri_irq = |(primary_flags_reg & primary_enable_reg);
    wire sec_irq = |(secondary_flags_reg & secondary_enable_reg);

    // pin levels; the secondary interrupt code follows secondary flags and enables
    wire pin1_level  = pin_level(live_in, ~sec_irq, pin_sel_reg.alt_en[0],
                                 pin_sel_reg.pin1_function_field, otd_pkg::OTD_F_VOLT_ZX);
    wire pin21_level = pin_level(live_in, ~sec_irq, pin_sel_reg.alt_en[1],
                                 pin_sel_reg.pin21_function_field, otd_pkg::OTD_F_CUR_ZX);
    wire pin20_level = pin_level(live_in, ~sec_irq, pin_sel_reg.alt_en[2],
                                 pin_sel_reg.pin20_function_field, otd_pkg::OTD_F_REV_PWR);

    // ----------------------------------------
    // read data select
    // ----------------------------------------
    wire [`OTD_BUS_W-1:0] rd_mux =
        (reg_addr_in == `OTD_A_VOLT_LIM)  ? `OTD_BUS_W'(volt_limit_reg) :
        (reg_addr_in == `OTD_A_CUR_LIM)   ? `OTD_BUS_W'(current_limit_reg) :
        (reg_addr_in == `OTD_A_PIN_SEL)   ? `OTD_BUS_W'(pin_sel_reg) :
        (reg_addr_in == `OTD_A_PRI_EN)    ? `OTD_BUS_W'(primary_enable_reg) :
        (reg_addr_in == `OTD_A_SEC_EN)    ? `OTD_BUS_W'(secondary_enable_reg) :
        (reg_addr_in == `OTD_A_PRI_FLAGS || reg_addr_in == `OTD_A_PRI_CLR)
                                          ? `OTD_BUS_W'(primary_flags_reg) :
        (reg_addr_in == `OTD_A_SEC_FLAGS || reg_addr_in == `OTD_A_SEC_CLR)
                                          ? `OTD_BUS_W'(secondary_flags_reg) :
        `OTD_BUS_W'(0);

    // ----------------------------------------
    // configuration registers
    // ----------------------------------------

    // limits
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            volt_limit_reg    <= DATA_W'(`OTD_LIMIT_RST);
            current_limit_reg <= DATA_W'(`OTD_LIMIT_RST);
        end else if (soft_reset_in) begin
            volt_limit_reg    <= DATA_W'(`OTD_LIMIT_RST);
            current_limit_reg <= DATA_W'(`OTD_LIMIT_RST);
        end else begin
            if (wr_volt) volt_limit_reg <= reg_wdata_in[DATA_W-1:0];
            if (wr_cur) current_limit_reg <= reg_wdata_in[DATA_W-1:0];
        end
    end

    // pin select and enables
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pin_sel_reg          <= `OTD_PIN_SEL_RST;
            primary_enable_reg   <= `OTD_PRI_EN_RST;
            secondary_enable_reg <= `OTD_SEC_EN_RST;
        end else if (soft_reset_in) begin
            pin_sel_reg          <= `OTD_PIN_SEL_RST;
            primary_enable_reg   <= `OTD_PRI_EN_RST;
            secondary_enable_reg <= `OTD_SEC_EN_RST;
        end else begin
            if (wr_pin) pin_sel_reg <= reg_wdata_in[`OTD_PIN_SEL_W-1:0];
            if (wr_pri_en) primary_enable_reg <= reg_wdata_in[`OTD_REG_W-1:0];
            if (wr_sec_en) secondary_enable_reg <= reg_wdata_in[`OTD_REG_W-1:0];
        end
    end

    // ----------------------------------------
    // status flags
    // ----------------------------------------

    // reset-done request, one cycle after any reset
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            boot_reg <= 1'b1;
        end else begin
            boot_reg <= soft_reset_in;
        end
    end

    // latched flags
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            primary_flags_reg   <= `OTD_FLAGS_RST;
            secondary_flags_reg <= `OTD_FLAGS_RST;
        end else if (soft_reset_in) begin
            primary_flags_reg   <= `OTD_FLAGS_RST;
            secondary_flags_reg <= `OTD_FLAGS_RST;
        end else begin
            primary_flags_reg   <= primary_flags_next;
            secondary_flags_reg <= secondary_flags_next;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------

    // read answer, value before any clear
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            reg_rdata_out  <= `OTD_BUS_W'(0);
            reg_rvalid_out <= 1'b0;
        end else begin
            reg_rdata_out  <= reg_rd_in ? rd_mux : reg_rdata_out;
            reg_rvalid_out <= reg_rd_in;
        end
    end

    // interrupt and multi-purpose pins
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            irq_b_out <= 1'b1;
            pin1_out  <= 1'b1;
            pin21_out <= 1'b1;
            pin20_out <= 1'b1;
        end else begin
            irq_b_out <= ~pri_irq;
            pin1_out  <= pin1_level;
            pin21_out <= pin21_level;
            pin20_out <= pin20_level;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);

    property p_volt_over_sets;
        volt_over && !soft_reset_in |=> primary_flags_reg[`OTD_BIT_VOLT_OVER];
    endproperty
    a_volt_over_sets: assert property (p_volt_over_sets) else $error("voltage flag not set");

    property p_strict_compare;
        sample_valid_in && volt_mag == volt_limit_reg && !soft_reset_in
            && !primary_flags_reg[`OTD_BIT_VOLT_OVER] |=> !primary_flags_reg[`OTD_BIT_VOLT_OVER];
    endproperty
    a_strict_compare: assert property (p_strict_compare) else $error("equal magnitude flagged");

    property p_chan_b_uses_cur;
        sample_valid_in && chan_b_mag > current_limit_reg && !soft_reset_in
            |=> secondary_flags_reg[`OTD_BIT_CHAN_B_OVER];
    endproperty
    a_chan_b_uses_cur: assert property (p_chan_b_uses_cur) else $error("channel B flag not set");

    property p_pri_clear;
        rd_pri_clr && primary_set == `OTD_FLAGS_RST |=> primary_flags_reg == `OTD_FLAGS_RST;
    endproperty
    a_pri_clear: assert property (p_pri_clear) else $error("primary flags not cleared");

    property p_sec_clear;
        rd_sec_clr && !chan_b_over ##1 !chan_b_over |=> secondary_flags_reg == `OTD_FLAGS_RST
            && $past(secondary_flags_reg, 2) == `OTD_REG_W'(reg_rdata_out);
    endproperty
    a_sec_clear: assert property (p_sec_clear) else $error("secondary clear read wrong");

    property p_irq_low;
        (|(primary_flags_reg & primary_enable_reg)) |=> !irq_b_out;
    endproperty
    a_irq_low: assert property (p_irq_low) else $error("interrupt not asserted");

    property p_irq_release;
        rd_pri_clr && primary_set == `OTD_FLAGS_RST && !soft_reset_in |=> ##1 irq_b_out;
    endproperty
    a_irq_release: assert property (p_irq_release) else $error("interrupt not released");

    property p_sec_pin_low;
        pin_sel_reg.alt_en[0] && pin_sel_reg.pin1_function_field == otd_pkg::OTD_F_SEC_IRQ
            && sec_irq |=> !pin1_out;
    endproperty
    a_sec_pin_low: assert property (p_sec_pin_low) else $error("routed pin not low");

    property p_default_pin;
        !pin_sel_reg.alt_en[1] |=> pin21_out == $past(live_in.current_zero_cross);
    endproperty
    a_default_pin: assert property (p_default_pin) else $error("default pin function wrong");

    property p_boot_flag;
        boot_reg |=> primary_flags_reg[`OTD_BIT_RESET_DONE] ##1 !irq_b_out;
    endproperty
    a_boot_flag: assert property (p_boot_flag) else $error("reset-done not raised");

    // channel A flag setting
    property p_chan_a_sets;
        chan_a_over && !soft_reset_in |=> primary_flags_reg[`OTD_BIT_CHAN_A_OVER];
    endproperty
    a_chan_a_sets: assert property (p_chan_a_sets) else $error("channel A flag not set");

    // interrupt pin stays high without an enabled flag
    property p_irq_high;
        !(|(primary_flags_reg & primary_enable_reg)) |=> irq_b_out;
    endproperty
    a_irq_high: assert property (p_irq_high) else $error("interrupt low without enabled flag");

    // software reset restores limits and enables
    property p_limit_reset;
        soft_reset_in |=> volt_limit_reg == DATA_W'(`OTD_LIMIT_RST)
            && current_limit_reg == DATA_W'(`OTD_LIMIT_RST);
    endproperty
    a_limit_reset: assert property (p_limit_reset) else $error("limits not restored");

    property p_enable_reset;
        soft_reset_in |=> primary_enable_reg == `OTD_PRI_EN_RST
            && secondary_enable_reg == `OTD_SEC_EN_RST;
    endproperty
    a_enable_reset: assert property (p_enable_reset) else $error("enables not restored");

    // routed functions follow their live level
    property p_sag_pin;
        pin_sel_reg.alt_en[2] && pin_sel_reg.pin20_function_field == otd_pkg::OTD_F_SAG
            |=> pin20_out == $past(live_in.sag);
    endproperty
    a_sag_pin: assert property (p_sag_pin) else $error("routed sag level wrong");

    property p_wave_pin;
        pin_sel_reg.alt_en[0] && pin_sel_reg.pin1_function_field == otd_pkg::OTD_F_WAVE_RDY
            |=> pin1_out == $past(live_in.wave_ready);
    endproperty
    a_wave_pin: assert property (p_wave_pin) else $error("routed data-ready level wrong");

endmodule

// *** bench/otd_host_model.sv ***
`include "otd_defs.svh"

module otd_host_model (
    // clock
    input  wire logic                   clk_in,
    // register port toward the device
    output logic                        reg_wr_out,
    output logic                        reg_rd_out,
    output logic [`OTD_ADDR_W-1:0]      reg_addr_out,
    output logic [`OTD_BUS_W-1:0]       reg_wdata_out,
    input  wire logic [`OTD_BUS_W-1:0]  reg_rdata_in,
    input  wire logic                   reg_rvalid_in,
    // interrupt pin from the device
    input  wire logic                   irq_b_in
);
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------
    // idle bus
    // ----------------------------------------
    initial begin
        reg_wr_out    = 1'b0;
        reg_rd_out    = 1'b0;
        reg_addr_out  = 10'h000;
        reg_wdata_out = 32'h00000000;
    end

    // ----------------------------------------
    // accesses
    // ----------------------------------------
    // one write strobe, then the bus shows inverted leftovers
    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        @(posedge clk_in);
        reg_wr_out    <= 1'b1;
        reg_addr_out  <= a;
        reg_wdata_out <= d;
        @(posedge clk_in);
        reg_wr_out    <= 1'b0;
        reg_addr_out  <= ~a;
        reg_wdata_out <= ~d;
    endtask

    // one read strobe, answer taken in the cycle after it
    task automatic rd(input logic [9:0] a, output logic [31:0] d, output logic ok);
        @(posedge clk_in);
        reg_rd_out   <= 1'b1;
        reg_addr_out <= a;
        @(posedge clk_in);
        reg_rd_out   <= 1'b0;
        reg_addr_out <= ~a;
        #1;
        ok = reg_rvalid_in;
        d  = reg_rdata_in;
    endtask

    // voltage limit from a peak reading scaled by six fifths
    task automatic set_volt_limit(input int unsigned peak);
        wr(`OTD_A_VOLT_LIM, 32'(peak * 6 / 5));
    endtask
endmodule

// *** bench/test_over_threshold_alt_pin_function_select_irq.sv ***
`include "otd_defs.svh"

module test_over_threshold_alt_pin_function_select_irq;
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------
    // signals and model state
    // ----------------------------------------
    logic                  clk_in, rst_b_in, soft_reset_in, sample_valid_in;
    logic [23:0]           volt_s, a_s, b_s;
    otd_pkg::otd_live_type live;
    logic                  reg_wr, reg_rd, reg_rvalid, irq_b, pin1, pin21, pin20;
    logic [9:0]            reg_addr;
    logic [31:0]           reg_wdata, reg_rdata;
    int unsigned           pri_fl, sec_fl, pri_en, sec_en, vlim, clim, psel, peak;
    int                    n_fail, comparisons, cycles;
    logic [9:0]            addrs[9] = '{10'h110, 10'h224, 10'h225, 10'h22C, 10'h22F,
                                        10'h22D, 10'h230, 10'h111, 10'h3FF};

    otd_top #(.DATA_W(24)) DUT (.clk_in(clk_in), .rst_b_in(rst_b_in), .soft_reset_in(soft_reset_in),
        .sample_valid_in(sample_valid_in), .volt_sample_in(volt_s), .chan_a_sample_in(a_s),
        .chan_b_sample_in(b_s), .live_in(live), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
        .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_rdata_out(reg_rdata),
        .reg_rvalid_out(reg_rvalid), .irq_b_out(irq_b), .pin1_out(pin1), .pin21_out(pin21),
        .pin20_out(pin20));
    otd_host_model host (.clk_in(clk_in), .reg_wr_out(reg_wr), .reg_rd_out(reg_rd),
        .reg_addr_out(reg_addr), .reg_wdata_out(reg_wdata), .reg_rdata_in(reg_rdata),
        .reg_rvalid_in(reg_rvalid), .irq_b_in(irq_b));

    // ----------------------------------------
    // clock and hang guard
    // ----------------------------------------
    initial begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            give_verdict();
        end
    end

    // ----------------------------------------
    // model and checks
    // ----------------------------------------
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic model_reset;
        pri_fl = 32'h00100000;
        pri_en = 32'h00100000;
        sec_fl = 32'h00000000;
        sec_en = 32'h00000000;
        vlim   = 32'h00FFFFFF;
        clim   = 32'h00FFFFFF;
        psel   = 32'h00000000;
    endtask
    function automatic int unsigned exp_reg(input logic [9:0] a);
        case (a)
            `OTD_A_PIN_SEL:                   return psel;
            `OTD_A_VOLT_LIM:                  return vlim;
            `OTD_A_CUR_LIM:                   return clim;
            `OTD_A_PRI_EN:                    return pri_en;
            `OTD_A_SEC_EN:                    return sec_en;
            `OTD_A_PRI_FLAGS, `OTD_A_PRI_CLR: return pri_fl;
            `OTD_A_SEC_FLAGS, `OTD_A_SEC_CLR: return sec_fl;
            default:                          return 32'h00000000;
        endcase
    endfunction
    // read, compare, and clear the model group on a clear read
    task automatic rd_chk(input logic [9:0] a);
        logic [31:0] d;
        logic        ok;
        host.rd(a, d, ok);
        check({31'h0, ok}, 32'h00000001, "read valid");
        check(d, exp_reg(a), "read data");
        if (a == `OTD_A_PRI_CLR) pri_fl = 0;
        if (a == `OTD_A_SEC_CLR) sec_fl = 0;
    endtask
    task automatic wr_m(input logic [9:0] a, input int unsigned d);
        host.wr(a, d);
        case (a)
            `OTD_A_PIN_SEL:  psel = d & 32'h0000FFFF;
            `OTD_A_VOLT_LIM: vlim = d & 32'h00FFFFFF;
            `OTD_A_CUR_LIM:  clim = d & 32'h00FFFFFF;
            `OTD_A_PRI_EN:   pri_en = d & 32'h00FFFFFF;
            `OTD_A_SEC_EN:   sec_en = d & 32'h00FFFFFF;
            default: ;
        endcase
    endtask
    function automatic int unsigned mag(input logic [23:0] s);
        return s[23] ? 32'h01000000 - s : s;
    endfunction
    task automatic sample(input logic [23:0] v, input logic [23:0] a, input logic [23:0] b);
        @(posedge clk_in);
        sample_valid_in <= 1'b1;
        {volt_s, a_s, b_s} <= {v, a, b};
        @(posedge clk_in);
        sample_valid_in <= 1'b0;
        {volt_s, a_s, b_s} <= ~{v, a, b};
        if (mag(v) > vlim) pri_fl |= 32'h00010000;
        if (mag(a) > clim) pri_fl |= 32'h00002000;
        if (mag(b) > clim) sec_fl |= 32'h00002000;
    endtask
    task automatic irq_chk;
        repeat (3) @(posedge clk_in);
        #1;
        check({31'h0, irq_b}, {31'h0, (pri_fl & pri_en) == 0}, "interrupt pin");
    endtask
    function automatic logic pin_exp(input int f);
        case (f)
            0:          return live.volt_zero_cross;
            1:          return live.current_zero_cross;
            2:          return live.reverse_power;
            3:          return live.sag;
            4, 5, 6, 7: return live.no_load[f-4];
            8:          return live.wave_ready;
            9:          return (sec_fl & sec_en) == 0;
            default:    return 1'b1;
        endcase
    endfunction
    task automatic pin_chk;
        logic [2:0] exp;
        repeat (3) @(posedge clk_in);
        #1;
        for (int q = 0; q < 3; q++) begin
            exp[q] = pin_exp(psel[12+q] ? int'((psel >> (4*q)) & 15) : q);
        end
        check({29'h0, pin20, pin21, pin1}, {29'h0, exp}, "pins");
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {rst_b_in, soft_reset_in, sample_valid_in, volt_s, a_s, b_s, live} = '0;
        void'($urandom(22293));
        repeat (10) @(posedge clk_in);
        rst_b_in <= 1'b1;
        model_reset();
        irq_chk();
        foreach (addrs[i]) rd_chk(addrs[i]);
        rd_chk(`OTD_A_PRI_CLR);
        irq_chk();
        sample(24'h800000, 24'h7FFFFF, 24'h800001);
        rd_chk(`OTD_A_PRI_FLAGS);
        wr_m(`OTD_A_PRI_FLAGS, $urandom);
        rd_chk(`OTD_A_PRI_FLAGS);
        wr_m(`OTD_A_CUR_LIM, $urandom);
        rd_chk(`OTD_A_CUR_LIM);
        wr_m(`OTD_A_CUR_LIM, $urandom & 32'h007FFFFF);
        peak = $urandom % 32'h006AAAAA;
        host.set_volt_limit(peak);
        vlim = peak * 6 / 5; // limit the host is meant to write
        rd_chk(`OTD_A_VOLT_LIM);
        wr_m(`OTD_A_PRI_EN, $urandom | 32'h00012000);
        wr_m(`OTD_A_SEC_EN, $urandom | 32'h00002000);
        sample(24'(vlim), 24'(-clim), 24'(clim));
        rd_chk(`OTD_A_PRI_FLAGS);
        irq_chk();
        sample(24'(-(vlim + 1)), 24'h000000, 24'h000000);
        rd_chk(`OTD_A_PRI_FLAGS);
        irq_chk();
        rd_chk(`OTD_A_PRI_CLR);
        irq_chk();
        sample(24'h000000, 24'(clim + 1), 24'h000000);
        irq_chk();
        rd_chk(`OTD_A_PRI_CLR);
        sample(24'h000000, 24'h000000, 24'(-(clim + 1)));
        rd_chk(`OTD_A_SEC_FLAGS);
        irq_chk();
        rd_chk(`OTD_A_SEC_CLR);
        wr_m(`OTD_A_PRI_EN, 32'h00000000);
        sample(24'(vlim + 1), 24'h000000, 24'h000000);
        rd_chk(`OTD_A_PRI_FLAGS);
        irq_chk();
        wr_m(`OTD_A_PRI_EN, 32'h00012000);
        repeat (20) begin
            sample(24'($urandom), 24'($urandom), 24'($urandom));
            rd_chk(`OTD_A_PRI_FLAGS);
            rd_chk(`OTD_A_SEC_FLAGS);
            irq_chk();
            if ($urandom % 2) rd_chk(`OTD_A_PRI_CLR);
        end
        sample(24'h000000, 24'h000000, 24'h800000);
        for (int i = 0; i < 32; i++) begin
            live <= otd_pkg::otd_live_type'(9'($urandom));
            wr_m(`OTD_A_PIN_SEL, {16'h0, 1'($urandom), i < 16 ? 3'h7 : 3'($urandom),
                4'((i + 10) % 16), 4'((i + 5) % 16), 4'(i)});
            pin_chk();
        end
        rd_chk(`OTD_A_SEC_FLAGS);
        wr_m(`OTD_A_PIN_SEL, 32'h00001009);
        wr_m(`OTD_A_SEC_EN, 32'h00000000);
        pin_chk();
        wr_m(`OTD_A_SEC_EN, 32'h00002000);
        pin_chk();
        rd_chk(`OTD_A_SEC_CLR);
        pin_chk();
        @(posedge clk_in);
        soft_reset_in <= 1'b1;
        @(posedge clk_in);
        soft_reset_in <= 1'b0;
        model_reset();
        repeat (2) @(posedge clk_in);
        foreach (addrs[i]) rd_chk(addrs[i]);
        give_verdict();
    end
endmodule
